// >>> core/rx_output_clock_and_reset.sv
// receive output clock pair generation, source/rate latches and device reset
`timescale 1ns/1ps

// ----------------------------------------
// overview
// ----------------------------------------
// four independent receive channels
// each channel owns one output clock pair
// true output comes from a divider flop
// complement output is a plain inverter
// so the pair can never overlap or skew in logic
// data and status registers follow the pair
// both pair edges move the data registers
// at character rate one edge per character
// at dual-character rate one edge per two ticks
//
// ----------------------------------------
// timing sources
// ----------------------------------------
// recovered tick: one pulse per recovered character
// reference tick: one pulse per reference period
// reference path has one extra flop of delay
// that delay lines the pair up with the data
// recovered path toggles one edge after its tick
// reference path toggles two edges after its tick
//
// ----------------------------------------
// configuration latches
// ----------------------------------------
// source latch: 0 recovered, 1 reference
// rate latch: 0 character, 1 dual-character
// a load strobe per channel writes both latches
// strobes may stand for many cycles back to back
// latches keep their value until the next strobe
// readback ports show the latched values
//
// ----------------------------------------
// half-rate reference
// ----------------------------------------
// reference source plus half-rate reference
// forces character divide, rate latch ignored
// recovered source keeps following the rate latch
// the half-rate level is taken live, not latched
//
// ----------------------------------------
// reset
// ----------------------------------------
// reset is asynchronous and active low
// every latch, divider and data flop clears
// the pair parks with true low, complement high
// the initial state holds after release
// the scan controller is outside this block
// and must be reset on its own
//
// ----------------------------------------
// limitations
// ----------------------------------------
// ticks are taken as synchronous to clk_sys
// two ticks in back-to-back cycles are honoured
// the divider phase is not cleared on a load
// so a dual-rate divide may start mid-pair
// the config machine only tracks strobe activity
// and steers nothing on the data path
module rx_output_clock_and_reset (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [rxclk_pkg::NUM_CHAN-1:0] cfg_wr,
  input wire logic [rxclk_pkg::NUM_CHAN-1:0] cfg_src_sel,
  input wire logic [rxclk_pkg::NUM_CHAN-1:0] cfg_rate_sel,
  input wire logic [rxclk_pkg::NUM_CHAN-1:0] recovered_tick,
  input wire logic [rxclk_pkg::NUM_CHAN-1:0] ref_tick,
  input wire logic [rxclk_pkg::NUM_CHAN-1:0] ref_half_rate,
  input wire logic [rxclk_pkg::NUM_CHAN*rxclk_pkg::WORD_W-1:0] word_in,
  input wire logic [rxclk_pkg::NUM_CHAN*rxclk_pkg::STAT_W-1:0] status_in,
  output logic [rxclk_pkg::NUM_CHAN-1:0] rx_iface_clock_pair_p,
  output logic [rxclk_pkg::NUM_CHAN-1:0] rx_iface_clock_pair_n,
  output logic [rxclk_pkg::NUM_CHAN*rxclk_pkg::WORD_W-1:0] rx_parallel_word,
  output logic [rxclk_pkg::NUM_CHAN*rxclk_pkg::STAT_W-1:0] rx_status_bits,
  output logic [rxclk_pkg::NUM_CHAN-1:0] rx_clock_source_select,
  output logic [rxclk_pkg::NUM_CHAN-1:0] rx_clock_rate_select
);

  localparam int N = rxclk_pkg::NUM_CHAN;
  localparam int WW = rxclk_pkg::WORD_W;
  localparam int SW = rxclk_pkg::STAT_W;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rxclk_pkg::cfg_state_e cfg;
    logic [N-1:0] src;
    logic [N-1:0] rate;
    logic [N-1:0] tick_d;
    logic [N*WW-1:0] word;
    logic [N*SW-1:0] stat;
  } top_s;

  top_s st_r;
  top_s st_nxt;

  logic [N-1:0] tick_sel;
  logic [N-1:0] half_eff;
  logic [N-1:0] clk_div;
  logic [N-1:0] edge_ev;

  // effective half-rate divide for one channel
  function automatic logic eff_half(input logic src, input logic rate, input logic ref_half);
    if (ref_half && src == rxclk_pkg::SRC_REFERENCE) begin
      eff_half = rxclk_pkg::RATE_CHAR;
    end else begin
      eff_half = rate;
    end
  endfunction

  // ----------------------------------------
  // divider per channel
  // ----------------------------------------
  for (genvar c = 0; c < N; c++) begin : g_ch
    rxclk_if lk ();
    assign lk.tick = tick_sel[c];
    assign lk.half_rate = half_eff[c];
    assign clk_div[c] = lk.clk_out;
    assign edge_ev[c] = lk.edge_ev;
    rxclk_div u_div (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .lk(lk.div)
    );
  end

  // source mux and effective rate
  always_comb begin
    for (int c = 0; c < N; c++) begin
      if (st_r.src[c] == rxclk_pkg::SRC_RECOVERED) begin
        tick_sel[c] = recovered_tick[c];
      end else begin
        tick_sel[c] = st_r.tick_d[c];
      end
      half_eff[c] = eff_half(st_r.src[c], st_r.rate[c], ref_half_rate[c]);
    end
  end

  // ----------------------------------------
  // latches and output registers
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick_d = ref_tick;
    unique case (st_r.cfg)
      rxclk_pkg::CFG_IDLE: begin
        if (|cfg_wr) begin
          st_nxt.cfg = rxclk_pkg::CFG_LOAD;
        end
      end
      rxclk_pkg::CFG_LOAD: begin
        st_nxt.cfg = rxclk_pkg::CFG_HOLD;
      end
      rxclk_pkg::CFG_HOLD: begin
        if (!(|cfg_wr)) begin
          st_nxt.cfg = rxclk_pkg::CFG_IDLE;
        end
      end
      default: begin
        st_nxt.cfg = rxclk_pkg::CFG_IDLE;
      end
    endcase
    for (int c = 0; c < N; c++) begin
      if (cfg_wr[c]) begin
        st_nxt.src[c] = cfg_src_sel[c];
        st_nxt.rate[c] = cfg_rate_sel[c];
      end
      // data updates on every output clock edge, both edges at either rate
      if (edge_ev[c]) begin
        st_nxt.word[c*WW +: WW] = word_in[c*WW +: WW];
        st_nxt.stat[c*SW +: SW] = status_in[c*SW +: SW];
      end
    end
  end

  // reset returns latches to initial values; scan controller not wired here
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r.cfg <= rxclk_pkg::CFG_IDLE;
      st_r.src <= {N{rxclk_pkg::SRC_SEL_RST}};
      st_r.rate <= {N{rxclk_pkg::RATE_SEL_RST}};
      st_r.tick_d <= '0;
      st_r.word <= '0;
      st_r.stat <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // clock pair and data outputs
  assign rx_iface_clock_pair_p = clk_div;
  assign rx_iface_clock_pair_n = ~clk_div;
  assign rx_parallel_word = st_r.word;
  assign rx_status_bits = st_r.stat;
  assign rx_clock_source_select = st_r.src;
  assign rx_clock_rate_select = st_r.rate;

endmodule

// >>> core/rxclk_div.sv
// one channel's output clock divider
`timescale 1ns/1ps
module rxclk_div (
  input wire logic clk_sys,
  input wire logic arst_n,
  rxclk_if.div lk
);

  typedef struct packed {
    logic phase;
    logic clk;
    logic ev;
  } div_s;

  div_s st_r;
  div_s st_nxt;

  // character rate toggles every tick, half rate every second tick
  always_comb begin
    st_nxt = st_r;
    st_nxt.ev = 1'h0;
    if (lk.tick) begin
      st_nxt.phase = ~st_r.phase;
      if (!lk.half_rate || st_r.phase) begin
        st_nxt.clk = ~st_r.clk;
        st_nxt.ev = 1'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lk.clk_out = st_r.clk;
  assign lk.edge_ev = st_r.ev;

endmodule

// >>> core/rxclk_if.sv
// per-channel divider connection between top and divider
`timescale 1ns/1ps
interface rxclk_if;
  logic tick;
  logic half_rate;
  logic clk_out;
  logic edge_ev;

  modport ctrl (
    output tick,
    output half_rate,
    input clk_out,
    input edge_ev
  );
  modport div (
    input tick,
    input half_rate,
    output clk_out,
    output edge_ev
  );
endinterface

// >>> core/rxclk_pkg.sv
// constants and types for the receive output clock and reset block
package rxclk_pkg;

  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int NUM_CHAN = 4;
  localparam int WORD_W = 8;
  localparam int STAT_W = 3;
  localparam logic SRC_SEL_RST = 1'h0;
  localparam logic RATE_SEL_RST = 1'h0;
  localparam logic SRC_RECOVERED = 1'h0;
  localparam logic SRC_REFERENCE = 1'h1;
  localparam logic RATE_CHAR = 1'h0;
  localparam logic RATE_HALF = 1'h1;
  localparam int ALIGN_DLY = 1;

  // configuration strobe tracking machine states
  typedef enum logic [1:0] {
    CFG_IDLE = 2'h0,
    CFG_LOAD = 2'h1,
    CFG_HOLD = 2'h3
  } cfg_state_e;

endpackage

// >>> test/rx_output_clock_and_reset_test.sv
// self-checking bench for the receive output clock and reset block
`timescale 1ns/1ps
module rx_output_clock_and_reset_test;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] wr = 4'h0, src = 4'h0, rate = 4'h0, rec = 4'h0, reft = 4'h0, half = 4'h0;
  logic [31:0] word_in = 32'h0;
  logic [11:0] status_in = 12'h0;
  logic [3:0] ckp, ckn, srco, rateo;
  logic [31:0] word_o;
  logic [11:0] stat_o;
  int edges, failures = 0, checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  rx_output_clock_and_reset uut (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_wr(wr),
    .cfg_src_sel(src), .cfg_rate_sel(rate), .recovered_tick(rec), .ref_tick(reft),
    .ref_half_rate(half), .word_in(word_in), .status_in(status_in),
    .rx_iface_clock_pair_p(ckp), .rx_iface_clock_pair_n(ckn), .rx_parallel_word(word_o),
    .rx_status_bits(stat_o), .rx_clock_source_select(srco), .rx_clock_rate_select(rateo));
  rxclk_host host (.clk_sys(clk_sys), .clk_p(ckp[0]), .edges(edges));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hold reset for five cycles and look at the initial state
  task automatic do_reset;
    @(negedge clk_sys) arst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("pair p", ckp, 4'h0);
    check("pair n", ckn, 4'hF);
    check("latches", {srco, rateo}, 8'h00);
    arst_n = 1'b1;
  endtask
  // load all channels, then read the latches back
  task automatic load(input logic s, input logic r, input logic h);
    @(negedge clk_sys);
    wr = 4'hF;
    src = {4{s}};
    rate = {4{r}};
    half = {4{h}};
    @(negedge clk_sys) wr = 4'h0;
    check("src latch", srco, {4{s}});
    check("rate latch", rateo, {4{r}});
  endtask
  // four ticks from each source, count clock edges, compare data
  task automatic run(input string what, input int exp);
    int e0;
    e0 = edges;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys);
      word_in = word_in + 32'h01010101;
      status_in = status_in + 12'h249;
      rec = 4'hF;
      @(negedge clk_sys) rec = 4'h0;
      reft = 4'hF;
      @(negedge clk_sys) reft = 4'h0;
      @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
    check(what, edges - e0, exp);
    check("word", word_o, word_in);
    check("status", stat_o, status_in);
    check("pair n", ckn, 4'(~ckp));
  endtask
  initial begin
    do_reset;
    load(0, 0, 0);
    run("rec char", 4);
    load(0, 1, 0);
    run("rec dual", 2);
    load(1, 0, 0);
    run("ref buffered", 4);
    load(1, 1, 0);
    run("ref divided", 2);
    load(0, 1, 1);
    run("half ref rec", 2);
    load(1, 1, 1);
    run("half ref forced", 4);
    do_reset;
    summarize;
  end
  // watchdog well beyond the expected run of under 150 cycles
  initial begin
    #20us;
    failures++;
    summarize;
  end
endmodule

// >>> test/rxclk_checker.sv
// channel 0 assertions for the receive output clock block
`timescale 1ns/1ps
module rxclk_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [3:0] cfg_wr,
  input wire logic [3:0] cfg_src_sel,
  input wire logic [3:0] cfg_rate_sel,
  input wire logic [3:0] recovered_tick,
  input wire logic [3:0] ref_tick,
  input wire logic [3:0] ref_half_rate,
  input wire logic [3:0] rx_iface_clock_pair_p,
  input wire logic [3:0] rx_iface_clock_pair_n,
  input wire logic [31:0] rx_parallel_word,
  input wire logic [3:0] rx_clock_source_select,
  input wire logic [3:0] rx_clock_rate_select
);
  logic s, r, p;
  assign s = rx_clock_source_select[0];
  assign r = rx_clock_rate_select[0];
  assign p = rx_iface_clock_pair_p[0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // selected tick that must toggle the clock
  sequence rec_fast; !s && !r && recovered_tick[0] && !cfg_wr[0]; endsequence
  sequence ref_fast; s && (!r || ref_half_rate[0]) && ref_tick[0] && !cfg_wr[0]; endsequence
  AST_COMPL: assert property (rx_iface_clock_pair_n[0] == !p)
    else $error("clock pair not complementary");
  AST_REC: assert property (rec_fast |=> p != $past(p))
    else $error("recovered tick did not toggle clock");
  AST_REF: assert property (ref_fast |-> ##2 p != $past(p))
    else $error("reference tick did not toggle clock");
  AST_QUIET: assert property (!s && !recovered_tick[0] && !cfg_wr[0] |=> $stable(p))
    else $error("clock moved without recovered tick");
  AST_SRC: assert property (cfg_wr[0] |=> s == $past(cfg_src_sel[0]))
    else $error("source latch not loaded");
  AST_RATE: assert property (cfg_wr[0] |=> r == $past(cfg_rate_sel[0]))
    else $error("rate latch not loaded");
  AST_HOLD: assert property (!cfg_wr[0] |=> $stable(s) && $stable(r))
    else $error("latch changed without load");
  AST_INIT: assert property ($rose(arst_n) |-> !p && !s && !r)
    else $error("state not initial after reset");
  AST_DATA: assert property ($stable(p) |=> $stable(rx_parallel_word[7:0]))
    else $error("data moved without clock edge");
endmodule
bind rx_output_clock_and_reset rxclk_checker chk (.clk_sys, .arst_n, .cfg_wr, .cfg_src_sel,
  .cfg_rate_sel, .recovered_tick, .ref_tick, .ref_half_rate, .rx_iface_clock_pair_p,
  .rx_iface_clock_pair_n, .rx_parallel_word, .rx_clock_source_select, .rx_clock_rate_select);

// >>> test/rxclk_host.sv
// host capture model counting channel 0 output clock edges
`timescale 1ns/1ps
module rxclk_host (
  input wire logic clk_sys,
  input wire logic clk_p,
  output int edges
);
  logic seen = 1'b0;
  initial edges = 0;
  // each level change of the true clock is one capture event
  always @(negedge clk_sys) begin
    if (clk_p !== seen) edges <= edges + 1;
    seen <= clk_p;
  end
endmodule
